/* File: src/viu_ack_seq.sv */
// Bus-state sequencer for one interrupt acknowledge cycle.
`timescale 1ns/1ps
`include "viu_consts.svh"

module viu_ack_seq
	import viu_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_ce,
	input  wire logic       i_start,
	input  wire logic       i_ext_wait,
	output viu_state_e      o_state_q,
	output viu_state_e      o_state_d
);

	viu_state_e state_q;
	viu_state_e state_d;
	logic [1:0] wait_q;
	logic [1:0] wait_d;

	// ============================================================
	// Next state: T1, T2, optional waits, T3, then one done cycle.
	always_comb begin
		state_d = state_q;
		wait_d  = wait_q;
		if (i_ce) begin
			case (state_q)
				VIU_ST_IDLE: begin
					if (i_start) begin
						state_d = VIU_ST_T1;
						wait_d  = i_ext_wait ? 2'(`VIU_EXT_WAIT_STATES) : 2'h0;
					end
				end
				VIU_ST_T1: state_d = VIU_ST_T2;
				VIU_ST_T2: state_d = (wait_q != 2'h0) ? VIU_ST_TW : VIU_ST_T3;
				VIU_ST_TW: begin
					wait_d  = wait_q - 2'h1;
					state_d = (wait_q == 2'h1) ? VIU_ST_T3 : VIU_ST_TW;
				end
				VIU_ST_T3:   state_d = VIU_ST_DONE;
				VIU_ST_DONE: state_d = VIU_ST_IDLE;
				default:     state_d = VIU_ST_IDLE;
			endcase
		end
	end

	// Registers the sequencer state.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_q <= VIU_ST_IDLE;
			wait_q  <= 2'h0;
		end else begin
			state_q <= state_d;
			wait_q  <= wait_d;
		end
	end

	assign o_state_q = state_q;
	assign o_state_d = state_d;

endmodule // viu_ack_seq

/* File: src/viu_consts.svh */
// Offsets, reset values, fixed vector codes and timing counts of the vectored interrupt unit.
`ifndef VIU_CONSTS_SVH
`define VIU_CONSTS_SVH

// ============================================================
// Register selects on the core write port
`define VIU_SEL_VECTOR_PAGE     2'h0
`define VIU_SEL_VECTOR_LOW_BASE 2'h1
`define VIU_SEL_TRAP_IRQ_CTRL   2'h2

// ============================================================
// Reset values
`define VIU_VECTOR_PAGE_RST     8'h00
`define VIU_VECTOR_LOW_BASE_RST 3'h0
`define VIU_TRAP_CTRL_EN_RST    3'h1
`define VIU_IM_RST              2'h0

// ============================================================
// Field positions of trap_irq_control and vector_low_base
`define VIU_TIC_A_EN_BIT        0
`define VIU_TIC_B_EN_BIT        1
`define VIU_TIC_C_EN_BIT        2
`define VIU_VLB_MSB             7
`define VIU_VLB_LSB             5

// ============================================================
// Fixed restart addresses
`define VIU_MODE1_ADDR          16'h0038
`define VIU_NMI_ADDR            16'h0066

// ============================================================
// Fixed low codes, highest priority first
`define VIU_CODE_EXT_B          5'h00
`define VIU_CODE_EXT_C          5'h02
`define VIU_CODE_TMR0           5'h04
`define VIU_CODE_TMR1           5'h06
`define VIU_CODE_DMA0           5'h08
`define VIU_CODE_DMA1           5'h0a
`define VIU_CODE_CSIO           5'h0c
`define VIU_CODE_ASYNC0         5'h0e
`define VIU_CODE_ASYNC1         5'h10

// ============================================================
// Peripheral count, acknowledge timing and idle opcode
`define VIU_NUM_PERIPH          7
`define VIU_EXT_WAIT_STATES     2
`define VIU_OPCODE_IDLE         8'h00

`endif

/* File: src/viu_pkg.sv */
// Types shared by the vectored interrupt unit.
package viu_pkg;

	// Bus states of one acknowledge cycle.
	typedef enum logic [2:0] {
		VIU_ST_IDLE,
		VIU_ST_T1,
		VIU_ST_T2,
		VIU_ST_TW,
		VIU_ST_T3,
		VIU_ST_DONE
	} viu_state_e;

	// Kind of request taken at the sample point.
	typedef enum logic [2:0] {
		VIU_K_NMI,
		VIU_K_MODE0,
		VIU_K_MODE1,
		VIU_K_MODE2,
		VIU_K_INTERNAL
	} viu_kind_e;

endpackage

/* File: src/viu_top.sv */
// Interrupt acceptance, masking, vector forming and acknowledge control of the CPU.
//
// Behaviour
// - mode 1 acceptance stacks PC, jumps 0038H.
// - mode 1 acceptance clears both enable flags.
// - vector table holds two-byte entries, low first.
// - vector page register gives upper address byte.
// - mode 2 low vector captured from bus.
// - mode 2 stacks PC then reads table.
// - external vector read: strobes low, two waits.
// - reset loads vector page with zero.
// - other vectors: base bits plus fixed code.
// - fixed low codes and priority order.
// - second and third inputs masked globally, individually.
// - reset: first input enabled, others cleared.
// - peripheral requests masked globally and individually.
// - reset clears vector low base bits.
// - maskable inputs sampled low at sample point.
// - control signal states during each acknowledge.
// - enable instruction sets global enable flag.
// - first input masked by either enable low.
// - non-maskable input outranks all maskable inputs.
// - mode 0 fetches opcode, no PC stacking.
`timescale 1ns/1ps
`include "viu_consts.svh"

module viu_top
	import viu_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_nmi_n,
	input  wire logic        i_ext_irq_a_n,
	input  wire logic        i_ext_irq_b_n,
	input  wire logic        i_ext_irq_c_n,
	input  wire logic [7:0]  i_data_bus,
	input  wire logic [6:0]  i_periph_req,
	input  wire logic [6:0]  i_periph_en,
	input  wire logic        i_sample_point,
	input  wire logic        i_irq_enable_instr,
	input  wire logic        i_irq_disable_instr,
	input  wire logic        i_nmi_return_instr,
	input  wire logic        i_set_mode,
	input  wire logic [1:0]  i_mode,
	input  wire logic        i_reg_wr,
	input  wire logic [1:0]  i_reg_sel,
	input  wire logic [7:0]  i_reg_wdata,
	output logic             o_opcode_fetch_strobe_n,
	output logic             o_io_enable_n,
	output logic             o_status_line,
	output logic             o_wait_state,
	output logic             o_ack_busy,
	output logic             o_irq_done,
	output logic             o_push_pc,
	output logic             o_table_fetch,
	output logic             o_mode0_exec,
	output logic [15:0]      o_target_addr,
	output logic [7:0]       o_opcode,
	output logic [7:0]       o_vector_page,
	output logic [7:0]       o_vector_low_base,
	output logic [7:0]       o_trap_irq_control,
	output logic             o_global_irq_enable,
	output logic             o_saved_irq_enable
);

	// ============================================================
	// Pin synchronisers; only the second stage is read by logic.
	logic [11:0] sync1_q;
	logic [11:0] sync2_q;
	logic        nmi_prev_q;
	logic        nmi_pend_q, nmi_pend_d;

	// Two flip-flops for every pin input.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sync1_q <= 12'hfff;
			sync2_q <= 12'hfff;
		end else if (i_ce) begin
			sync1_q <= {i_nmi_n, i_ext_irq_a_n, i_ext_irq_b_n, i_ext_irq_c_n, i_data_bus};
			sync2_q <= sync1_q;
		end
	end

	logic       nmi_s_n;
	logic       irq_a_s_n;
	logic       irq_b_s_n;
	logic       irq_c_s_n;
	logic [7:0] data_s;

	assign {nmi_s_n, irq_a_s_n, irq_b_s_n, irq_c_s_n, data_s} = sync2_q;

	// ============================================================
	// Programmable state.
	logic [7:0] vector_page_q, vector_page_d;
	logic [2:0] vlb_q, vlb_d;
	logic [2:0] tic_en_q, tic_en_d;
	logic [1:0] im_q, im_d;
	logic       gie_q, gie_d;
	logic       sie_q, sie_d;

	// ============================================================
	// Acknowledge bookkeeping.
	viu_kind_e  kind_q, kind_d;
	logic [4:0] code_q, code_d;
	logic [7:0] cap_q, cap_d;
	viu_state_e seq_q, seq_d;
	logic       start;
	logic       ext_wait;

	// ============================================================
	// Request masking and priority choice.
	logic       req_a;
	logic       req_b;
	logic       req_c;
	logic [6:0] req_p;
	logic       take;
	viu_kind_e  take_kind;
	logic [4:0] take_code;

	assign req_a = ~irq_a_s_n & gie_q & tic_en_q[`VIU_TIC_A_EN_BIT];
	assign req_b = ~irq_b_s_n & gie_q & tic_en_q[`VIU_TIC_B_EN_BIT];
	assign req_c = ~irq_c_s_n & gie_q & tic_en_q[`VIU_TIC_C_EN_BIT];
	assign req_p = i_periph_req & i_periph_en & {7{gie_q}};

	// Picks the winner, non-maskable first, then the fixed order.
	always_comb begin
		take      = 1'b0;
		take_kind = VIU_K_INTERNAL;
		take_code = `VIU_CODE_EXT_B;
		if (nmi_pend_q) begin
			take      = 1'b1;
			take_kind = VIU_K_NMI;
		end else if (req_a) begin
			take      = 1'b1;
			take_kind = (im_q == 2'h2) ? VIU_K_MODE2 :
			            (im_q == 2'h1) ? VIU_K_MODE1 : VIU_K_MODE0;
		end else if (req_b) begin
			take      = 1'b1;
			take_code = `VIU_CODE_EXT_B;
		end else if (req_c) begin
			take      = 1'b1;
			take_code = `VIU_CODE_EXT_C;
		end else begin
			// Peripheral codes step by two from the first timer; the lowest index wins.
			for (int i = 6; i >= 0; i--) begin
				if (req_p[i]) begin
					take      = 1'b1;
					take_code = `VIU_CODE_TMR0 + 5'(2 * i);
				end
			end
		end
	end

	// Requests are taken only at the sample point of a last machine cycle.
	assign start    = i_ce & i_sample_point & take & (seq_q == VIU_ST_IDLE);
	assign ext_wait = (take_kind == VIU_K_MODE0) | (take_kind == VIU_K_MODE2);

	viu_ack_seq u_seq (
		.i_mclk     (i_mclk),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.i_start    (start),
		.i_ext_wait (ext_wait),
		.o_state_q  (seq_q),
		.o_state_d  (seq_d)
	);

	// ============================================================
	// Next values of flags, registers and the taken request.
	always_comb begin
		vector_page_d = vector_page_q;
		vlb_d         = vlb_q;
		tic_en_d      = tic_en_q;
		im_d          = im_q;
		gie_d         = gie_q;
		sie_d         = sie_q;
		kind_d        = kind_q;
		code_d        = code_q;
		cap_d         = cap_q;
		nmi_pend_d    = nmi_pend_q;
		if (i_ce) begin
			// The falling edge is latched and held until taken; a new edge wins.
			if (start && take_kind == VIU_K_NMI) begin
				nmi_pend_d = 1'b0;
			end
			if (nmi_prev_q && !nmi_s_n) begin
				nmi_pend_d = 1'b1;
			end
			if (i_reg_wr) begin
				case (i_reg_sel)
					`VIU_SEL_VECTOR_PAGE:     vector_page_d = i_reg_wdata;
					`VIU_SEL_VECTOR_LOW_BASE: vlb_d = i_reg_wdata[`VIU_VLB_MSB:`VIU_VLB_LSB];
					`VIU_SEL_TRAP_IRQ_CTRL:   tic_en_d = i_reg_wdata[2:0];
					default:                  ;
				endcase
			end
			if (i_set_mode) begin
				im_d = i_mode;
			end
			if (i_irq_enable_instr) begin
				gie_d = 1'b1;
				sie_d = 1'b1;
			end else if (i_irq_disable_instr) begin
				gie_d = 1'b0;
				sie_d = 1'b0;
			end else if (i_nmi_return_instr) begin
				gie_d = sie_q;
			end
			if (start) begin
				kind_d = take_kind;
				code_d = take_code;
				if (take_kind == VIU_K_NMI) begin
					sie_d = gie_q;
					gie_d = 1'b0;
				end else begin
					gie_d = 1'b0;
					sie_d = 1'b0;
				end
			end
			// Low vector or opcode is taken from the bus at the end of T3.
			if (seq_q == VIU_ST_T3) begin
				cap_d = data_s;
			end
		end
	end

	// Registers the programmable and bookkeeping state.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			vector_page_q <= `VIU_VECTOR_PAGE_RST;
			vlb_q         <= `VIU_VECTOR_LOW_BASE_RST;
			tic_en_q      <= `VIU_TRAP_CTRL_EN_RST;
			im_q          <= `VIU_IM_RST;
			gie_q         <= 1'b0;
			sie_q         <= 1'b0;
			kind_q        <= VIU_K_MODE0;
			code_q        <= 5'h00;
			cap_q         <= `VIU_OPCODE_IDLE;
			nmi_pend_q    <= 1'b0;
			nmi_prev_q    <= 1'b1;
		end else begin
			vector_page_q <= vector_page_d;
			vlb_q         <= vlb_d;
			tic_en_q      <= tic_en_d;
			im_q          <= im_d;
			gie_q         <= gie_d;
			sie_q         <= sie_d;
			kind_q        <= kind_d;
			code_q        <= code_d;
			cap_q         <= cap_d;
			nmi_pend_q    <= nmi_pend_d;
			if (i_ce) begin
				nmi_prev_q <= nmi_s_n;
			end
		end
	end

	// ============================================================
	// Output values; done from the current sequencer state, the rest from the next.
	logic        in_ack_d, ext_ack_d, done_d;
	logic [15:0] target_d;
	logic        push_d, table_d, mode0_d;
	viu_kind_e   kind_ack;

	assign kind_ack  = start ? take_kind : kind_q;
	assign in_ack_d  = (seq_d != VIU_ST_IDLE) && (seq_d != VIU_ST_DONE);
	assign ext_ack_d = in_ack_d && (kind_ack != VIU_K_NMI) && (kind_ack != VIU_K_INTERNAL);
	assign done_d    = i_ce && (seq_q == VIU_ST_DONE);

	// Forms the resume address or table pointer for the finished acknowledge.
	always_comb begin
		target_d = {vector_page_q, vlb_q, code_q};
		push_d   = 1'b1;
		table_d  = 1'b1;
		mode0_d  = 1'b0;
		case (kind_q)
			VIU_K_NMI: begin
				target_d = `VIU_NMI_ADDR;
				table_d  = 1'b0;
			end
			VIU_K_MODE0: begin
				target_d = 16'h0000;
				push_d   = 1'b0;
				table_d  = 1'b0;
				mode0_d  = 1'b1;
			end
			VIU_K_MODE1: begin
				target_d = `VIU_MODE1_ADDR;
				table_d  = 1'b0;
			end
			VIU_K_MODE2: target_d = {vector_page_q, cap_q};
			default:     ;
		endcase
	end

	// Registers the acknowledge outputs; the read-back outputs below are assigned directly.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_opcode_fetch_strobe_n <= 1'b1;
			o_io_enable_n           <= 1'b1;
			o_status_line           <= 1'b1;
			o_wait_state            <= 1'b0;
			o_ack_busy              <= 1'b0;
			o_irq_done              <= 1'b0;
			o_push_pc               <= 1'b0;
			o_table_fetch           <= 1'b0;
			o_mode0_exec            <= 1'b0;
			o_target_addr           <= 16'h0000;
			o_opcode                <= `VIU_OPCODE_IDLE;
		end else begin
			o_opcode_fetch_strobe_n <= ~ext_ack_d;
			o_io_enable_n           <= ~ext_ack_d;
			o_status_line           <= ~in_ack_d;
			o_wait_state            <= (seq_d == VIU_ST_TW);
			o_ack_busy              <= (seq_d != VIU_ST_IDLE);
			o_irq_done              <= done_d;
			o_push_pc               <= done_d & push_d;
			o_table_fetch           <= done_d & table_d;
			o_mode0_exec            <= done_d & mode0_d;
			if (done_d) begin
				o_target_addr <= target_d;
				o_opcode      <= cap_q;
			end
		end
	end

	// Register read-back; unused bits read as zero.
	assign o_vector_page       = vector_page_q;
	assign o_vector_low_base   = {vlb_q, 5'h00};
	assign o_trap_irq_control  = {5'h00, tic_en_q};
	assign o_global_irq_enable = gie_q;
	assign o_saved_irq_enable  = sie_q;

endmodule // viu_top

/* File: tb/test_vectored_interrupt_unit.sv */
// Self-checking testbench of the vectored interrupt unit.
`timescale 1ns/1ps
`include "viu_consts.svh"

module test_vectored_interrupt_unit;
	logic        clk, rst, sp, ei, di, setm, wr;
	logic [1:0]  mode, sel;
	logic [7:0]  wd, vec, dbus;
	logic [10:0] want;
	logic [6:0]  pen, preq;
	logic        nmi_n, a_n, b_n, c_n, lir_n, ioe_n, st, ws, busy, done, push, tbl, m0;
	logic        gie, sie;
	logic [15:0] tgt;
	logic [7:0]  opc, page, base, trap;
	int          failures, checks, cyc;

	viu_top DUT (.i_mclk(clk), .i_rst(rst), .i_ce(1'b1), .i_nmi_n(nmi_n), .i_ext_irq_a_n(a_n),
		.i_ext_irq_b_n(b_n), .i_ext_irq_c_n(c_n), .i_data_bus(dbus), .i_periph_req(preq),
		.i_periph_en(pen), .i_sample_point(sp), .i_irq_enable_instr(ei),
		.i_irq_disable_instr(di), .i_nmi_return_instr(1'b0), .i_set_mode(setm), .i_mode(mode),
		.i_reg_wr(wr), .i_reg_sel(sel), .i_reg_wdata(wd), .o_opcode_fetch_strobe_n(lir_n),
		.o_io_enable_n(ioe_n), .o_status_line(st), .o_wait_state(ws), .o_ack_busy(busy),
		.o_irq_done(done), .o_push_pc(push), .o_table_fetch(tbl), .o_mode0_exec(m0),
		.o_target_addr(tgt), .o_opcode(opc), .o_vector_page(page), .o_vector_low_base(base),
		.o_trap_irq_control(trap), .o_global_irq_enable(gie), .o_saved_irq_enable(sie));

	viu_requester u_req (.i_mclk(clk), .i_rst(rst), .i_want(want), .i_vec(vec),
		.i_ack_lo(!lir_n && !ioe_n), .o_nmi_n(nmi_n), .o_irq_a_n(a_n), .o_irq_b_n(b_n),
		.o_irq_c_n(c_n), .o_data(dbus), .o_periph_req(preq));

	// Clock and timeout watchdog.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			finish_test();
		end
	end

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
	endtask

	task automatic wreg(input logic [1:0] s, input logic [7:0] d);
		sel = s;
		wd = d;
		pulse(wr);
	endtask

	task automatic setmode(input logic [1:0] m);
		mode = m;
		pulse(setm);
	endtask

	// Arms a request set, enables interrupts and lets the pins pass the synchroniser.
	task automatic arm(input logic [10:0] w);
		want = w;
		pulse(ei);
		repeat (4) @(negedge clk);
	endtask

	// Runs one acknowledge and compares its outcome; f is push, table, mode0, flags.
	task automatic ack(input logic [15:0] t, input logic lo, input int nw, input logic [4:0] f);
		int w;
		logic sl, dn, sa;
		w = 0;
		sl = 1'b1;
		dn = 1'b0;
		sa = 1'b0;
		pulse(sp);
		for (int i = 0; i < 20 && !dn; i++) begin
			@(negedge clk);
			w += ws;
			if (!lir_n) sl = 1'b0;
			if (!st) sa = 1'b1;
			if (done) begin
				dn = 1'b1;
				chk("pulses", {push, tbl, m0, gie, sie}, f);
			end
		end
		chk("done", dn, 1'b1);
		chk("target", tgt, t);
		chk("strobe", sl, !lo);
		chk("status", sa, 1'b1);
		chk("waits", w, nw);
		repeat (2) @(negedge clk);
	endtask

	task automatic no_ack();
		pulse(sp);
		repeat (3) @(negedge clk);
		chk("busy", busy, 1'b0);
	endtask

	task automatic t_reset();
		chk("page", page, 8'h00);
		chk("base", base, 8'h00);
		chk("trap", trap, 8'h01);
		chk("flags", {gie, sie}, 2'h0);
		$display("reset test done");
	endtask

	task automatic t_regs();
		wreg(2'h0, 8'ha5);
		chk("page", page, 8'ha5);
		wreg(2'h1, 8'hff);
		chk("base", base, 8'he0);
		wreg(2'h3, 8'h00);
		chk("unmapped", {page, base}, 16'ha5e0);
		wreg(2'h2, 8'h06);
		chk("trap", trap, 8'h06);
		$display("register test done");
	endtask

	task automatic t_mode1();
		setmode(2'h1);
		want = 11'h001;
		repeat (4) @(negedge clk);
		no_ack();
		arm(11'h001);
		chk("flags", {gie, sie}, 2'h3);
		no_ack();
		wreg(2'h2, 8'h07);
		arm(11'h001);
		ack(`VIU_MODE1_ADDR, 1'b1, 0, 5'b10000);
		$display("mode 1 test done");
	endtask

	task automatic t_mode2();
		wreg(2'h0, 8'h5a);
		setmode(2'h2);
		vec = 8'h42;
		arm(11'h001);
		ack(16'h5a42, 1'b1, 2, 5'b11000);
		setmode(2'h0);
		vec = 8'hc7;
		arm(11'h001);
		ack(16'h0000, 1'b1, 2, 5'b00100);
		chk("opcode", opc, 8'hc7);
		$display("mode 2 and 0 test done");
	endtask

	// All vectored sources pending together; each acknowledge takes the highest left.
	task automatic t_vect();
		logic [10:0] w;
		w = 11'h7f6;
		want = 11'h000;
		wreg(2'h1, 8'h60);
		for (int i = 0; i < 9; i++) begin
			arm(w);
			ack({8'h5a, 3'h3, 5'(2 * i)}, 1'b0, 0, 5'b11000);
			w[i < 2 ? i + 1 : i + 2] = 1'b0;
		end
		$display("vector table test done");
	endtask

	task automatic t_mask();
		pen = 7'h00;
		wreg(2'h2, 8'h01);
		arm(11'h7f6);
		no_ack();
		pen = 7'h7f;
		wreg(2'h2, 8'h07);
		pulse(di);
		no_ack();
		setmode(2'h1);
		arm(11'h009);
		ack(`VIU_NMI_ADDR, 1'b0, 0, 5'b10001);
		arm(11'h001);
		ack(`VIU_MODE1_ADDR, 1'b1, 0, 5'b10000);
		want = 11'h000;
		$display("mask and priority test done");
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence.
	initial begin
		{rst, sp, ei, di, setm, wr, mode, sel, wd, vec, want, pen} = '0;
		rst = 1'b1;
		pen = 7'h7f;
		failures = 0;
		checks = 0;
		cyc = 0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		t_reset();
		t_regs();
		t_mode1();
		t_mode2();
		t_vect();
		t_mask();
		finish_test();
	end
endmodule // test_vectored_interrupt_unit

/* File: tb/viu_checker_assertions.sv */
// Concurrent checks on the ports of the vectored interrupt unit.
`timescale 1ns/1ps

// ============================================================
// Checker module
module viu_checker (
	input wire logic        i_mclk,
	input wire logic        i_rst,
	input wire logic        i_ce,
	input wire logic        i_sample_point,
	input wire logic        i_irq_enable_instr,
	input wire logic        i_reg_wr,
	input wire logic [1:0]  i_reg_sel,
	input wire logic [7:0]  i_reg_wdata,
	input wire logic        o_opcode_fetch_strobe_n,
	input wire logic        o_io_enable_n,
	input wire logic        o_status_line,
	input wire logic        o_wait_state,
	input wire logic        o_irq_done,
	input wire logic        o_push_pc,
	input wire logic        o_table_fetch,
	input wire logic        o_mode0_exec,
	input wire logic [15:0] o_target_addr,
	input wire logic [7:0]  o_vector_page,
	input wire logic [7:0]  o_vector_low_base,
	input wire logic        o_global_irq_enable,
	input wire logic        o_saved_irq_enable
);
	logic [7:0] wd_q;

	// Keeps last cycle's write data for the base register check.
	always_ff @(posedge i_mclk) begin
		wd_q <= i_reg_wdata;
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	strobe_pair_a:
	assert property (o_opcode_fetch_strobe_n == o_io_enable_n) else $error("strobes differ");
	strobe_status_a:
	assert property (!o_opcode_fetch_strobe_n |-> !o_status_line) else $error("status high");
	two_waits_a:
	assert property ($rose(o_wait_state) |=> o_wait_state ##1 !o_wait_state)
		else $error("wait count wrong");
	wait_strobe_a:
	assert property (o_wait_state |-> !o_opcode_fetch_strobe_n) else $error("wait outside fetch");
	page_write_a:
	assert property (i_ce && i_reg_wr && i_reg_sel == 2'h0 |=> o_vector_page == $past(i_reg_wdata))
		else $error("page not written");
	base_write_a:
	assert property (i_ce && i_reg_wr && i_reg_sel == 2'h1 |=>
		o_vector_low_base == {wd_q[7:5], 5'h00}) else $error("base not written");
	enable_set_a:
	assert property (i_ce && i_irq_enable_instr && !i_sample_point |=>
		o_global_irq_enable && o_saved_irq_enable) else $error("enable not set");
	mode0_nopush_a:
	assert property (o_mode0_exec |-> o_irq_done && !o_push_pc && !o_table_fetch)
		else $error("mode 0 stacked");
	table_page_a:
	assert property (o_irq_done && o_table_fetch |-> o_target_addr[15:8] == o_vector_page)
		else $error("pointer page wrong");
endmodule // viu_checker

bind viu_top viu_checker u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
	.i_sample_point(i_sample_point), .i_irq_enable_instr(i_irq_enable_instr),
	.i_reg_wr(i_reg_wr), .i_reg_sel(i_reg_sel), .i_reg_wdata(i_reg_wdata),
	.o_opcode_fetch_strobe_n(o_opcode_fetch_strobe_n), .o_io_enable_n(o_io_enable_n),
	.o_status_line(o_status_line), .o_wait_state(o_wait_state), .o_irq_done(o_irq_done),
	.o_push_pc(o_push_pc), .o_table_fetch(o_table_fetch), .o_mode0_exec(o_mode0_exec),
	.o_target_addr(o_target_addr), .o_vector_page(o_vector_page),
	.o_vector_low_base(o_vector_low_base), .o_global_irq_enable(o_global_irq_enable),
	.o_saved_irq_enable(o_saved_irq_enable));

/* File: tb/viu_requester.sv */
// Model of the external requesters and on-chip peripheral requesters.
`timescale 1ns/1ps

// ============================================================
// Requester model
module viu_requester (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic [10:0] i_want,
	input  wire logic [7:0]  i_vec,
	input  wire logic        i_ack_lo,
	output logic             o_nmi_n,
	output logic             o_irq_a_n,
	output logic             o_irq_b_n,
	output logic             o_irq_c_n,
	output logic [7:0]       o_data,
	output logic [6:0]       o_periph_req
);
	logic [10:0] req_q;
	logic [7:0]  pat_q;

	// Requests change just after the edge and are held until the bench drops them.
	always_ff @(posedge i_mclk) begin
		req_q <= i_rst ? 11'h000 : i_want;
		pat_q <= i_rst ? 8'h00 : pat_q + 8'h3b;
	end

	// Active-low pins; the bus carries a moving pattern when not answering.
	assign o_irq_a_n    = ~req_q[0];
	assign o_irq_b_n    = ~req_q[1];
	assign o_irq_c_n    = ~req_q[2];
	assign o_nmi_n      = ~req_q[3];
	assign o_periph_req = req_q[10:4];
	assign o_data       = i_ack_lo ? i_vec : pat_q;
endmodule // viu_requester
